// ===== logic/atten_pkg.sv
// Shared constants and carrier types for the serial attenuator control block
// Behaviour
// - Sample data on each serial clock rise
// - Shift only while load enable is low
// - Previous bit leaves on serial output
// - Word is channel byte then attenuation byte
// - MSB first, channel byte before attenuation
// - Unmatched channel byte changes no setting
// - Three independent channel settings
// - Codes 0x4F and above mute channel
// - All channels muted after power-up
// - Chain of n shifts 16n bits, one latch
// - Decode channel, drive its tap select
package atten_pkg;
  localparam int WORD_BITS = 16;
  localparam int BYTE_BITS = 8;
  localparam int CHAN_COUNT = 3;
  localparam int TAP_BITS = 7;
  localparam logic [7:0] MUTE_CODE = 8'h4F;
  localparam logic [7:0] CHAN1_ADDR = 8'h00;
  localparam logic [7:0] CHAN2_ADDR = 8'h01;
  localparam logic [7:0] CHAN3_ADDR = 8'h02;
  localparam logic [TAP_BITS-1:0] TAP_RESET = 7'h00;
  localparam logic [15:0] SHIFT_RESET = 16'h0000;
  // Synchroniser reset {load, clock, data}: the idle pin levels
  localparam logic [2:0] PIN_RESET = 3'h4;

  typedef struct packed {
    logic [7:0] chan;
    logic [7:0] atten;
  } word_s;

  typedef struct packed {
    logic mute;
    logic [TAP_BITS-1:0] tap;
  } setting_s;

  localparam setting_s SETTING_RESET = '{mute: 1'b1, tap: TAP_RESET};
endpackage : atten_pkg

// ===== logic/serial_attenuator_control.sv
// Serial attenuator control: shift register, latch and three channel settings
`timescale 1ns/1ns
module serial_attenuator_control #(
  parameter logic [7:0] CHAN1_ADDR = atten_pkg::CHAN1_ADDR,
  parameter logic [7:0] CHAN2_ADDR = atten_pkg::CHAN2_ADDR,
  parameter logic [7:0] CHAN3_ADDR = atten_pkg::CHAN3_ADDR
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk_i,
  input wire logic load_n_i,
  input wire logic data_i,
  output logic data_o,
  output logic [atten_pkg::CHAN_COUNT-1:0] mute_o,
  output logic [atten_pkg::CHAN_COUNT*atten_pkg::TAP_BITS-1:0] tap_o,
  output logic update_o
);
  localparam int N = atten_pkg::CHAN_COUNT;

  // Two-stage synchronisers for the three pins
  logic [2:0] meta_reg;
  logic [2:0] meta_next;
  logic [2:0] sync_reg;
  logic [2:0] sync_next;
  logic sclk_prev_reg;
  logic sclk_prev_next;
  always_comb begin
    meta_next = {load_n_i, sclk_i, data_i};
    sync_next = meta_reg;
    sclk_prev_next = sync_reg[1];
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      // Idle pin levels, so no false edge or latch follows reset
      meta_reg <= atten_pkg::PIN_RESET;
      sync_reg <= atten_pkg::PIN_RESET;
      sclk_prev_reg <= 1'b0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      sclk_prev_reg <= sclk_prev_next;
    end
  end

  logic sdat;
  logic sclk_rise;
  logic load_n;
  logic load_prev_reg;
  logic load_prev_next;
  logic latch_pulse;
  assign sdat = sync_reg[0];
  assign load_n = sync_reg[2];
  assign sclk_rise = sync_reg[1] && !sclk_prev_reg;
  assign latch_pulse = load_n && !load_prev_reg;

  // Shift register and serial output
  logic [15:0] shift_reg;
  logic [15:0] shift_next;
  logic data_out_reg;
  logic data_out_next;
  atten_pkg::word_s latched_reg;
  atten_pkg::word_s latched_next;
  logic pending_reg;
  logic pending_next;

  always_comb begin
    shift_next = shift_reg;
    data_out_next = data_out_reg;
    latched_next = latched_reg;
    pending_next = 1'b0;
    load_prev_next = load_n;
    if (sclk_rise && !load_n) begin
      // MSB first: channel byte ends in the upper half
      shift_next = {shift_reg[14:0], sdat};
      data_out_next = shift_reg[15];
    end
    if (latch_pulse) begin
      latched_next = atten_pkg::word_s'(shift_reg);
      pending_next = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shift_reg <= atten_pkg::SHIFT_RESET;
      data_out_reg <= 1'b0;
      latched_reg <= atten_pkg::word_s'(atten_pkg::SHIFT_RESET);
      pending_reg <= 1'b0;
      load_prev_reg <= 1'b1;
    end else begin
      shift_reg <= shift_next;
      data_out_reg <= data_out_next;
      latched_reg <= latched_next;
      pending_reg <= pending_next;
      load_prev_reg <= load_prev_next;
    end
  end

  // Decoded setting appears in the same cycle as the latched word
  atten_pkg::setting_s decoded;
  tap_lookup u_lookup (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .code_i(latched_next.atten),
    .setting_o(decoded)
  );

  function automatic logic [N-1:0] chan_hit(input logic [7:0] a);
    chan_hit = {a == CHAN3_ADDR, a == CHAN2_ADDR, a == CHAN1_ADDR};
  endfunction : chan_hit

  logic [N-1:0] hit;
  assign hit = chan_hit(latched_reg.chan);

  atten_pkg::setting_s chan_reg [N];
  atten_pkg::setting_s chan_next [N];
  logic update_reg;
  logic update_next;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_chan
      always_comb begin
        chan_next[g] = chan_reg[g];
        if (pending_reg && hit[g]) begin
          chan_next[g] = decoded;
        end
      end
      always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
          chan_reg[g] <= atten_pkg::SETTING_RESET;
        end else begin
          chan_reg[g] <= chan_next[g];
        end
      end
      assign mute_o[g] = chan_reg[g].mute;
      assign tap_o[g*atten_pkg::TAP_BITS +: atten_pkg::TAP_BITS] = chan_reg[g].tap;

      a_chan_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !(pending_reg && hit[g]) |=> $stable(chan_reg[g]))
        else $error("channel changed without matching word");
      a_chan_mute: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pending_reg && hit[g] && latched_reg.atten >= atten_pkg::MUTE_CODE
        |=> chan_reg[g].mute)
        else $error("mute code did not mute channel");
      a_chan_tap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        pending_reg && hit[g] && latched_reg.atten < atten_pkg::MUTE_CODE
        |=> !chan_reg[g].mute
            && chan_reg[g].tap == $past(latched_reg.atten[atten_pkg::TAP_BITS-1:0]))
        else $error("tap does not follow code");
      a_mute_tap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        chan_reg[g].mute |-> chan_reg[g].tap == atten_pkg::TAP_RESET)
        else $error("muted channel has a live tap");
      a_tap_range: assert property (@(posedge clk_i) disable iff (!rst_n_i)
        !chan_reg[g].mute |-> {1'b0, chan_reg[g].tap} < atten_pkg::MUTE_CODE)
        else $error("live tap outside code range");
    end
  endgenerate

  always_comb begin
    update_next = pending_reg && (|hit);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      update_reg <= 1'b0;
    end else begin
      update_reg <= update_next;
    end
  end

  assign data_o = data_out_reg;
  assign update_o = update_reg;

  a_shift_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(sclk_rise && !load_n) |=> $stable(shift_reg))
    else $error("shift register moved without enabled edge");
  a_shift_in: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sclk_rise && !load_n |=> shift_reg[0] == $past(sdat)
      && shift_reg[15:1] == $past(shift_reg[14:0]))
    else $error("bit not sampled on rising edge");
  a_data_out: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sclk_rise && !load_n |=> data_o == $past(shift_reg[15]))
    else $error("serial output not previous top bit");
  a_latch_word: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    latch_pulse |=> pending_reg && latched_reg == $past(shift_reg))
    else $error("word not latched on enable rise");
  a_reset_mute: assert property (@(posedge clk_i)
    !rst_n_i |=> &mute_o)
    else $error("channels not muted after reset");
  a_reset_quiet: assert property (@(posedge clk_i)
    !rst_n_i |=> !update_o && !data_o && shift_reg == atten_pkg::SHIFT_RESET)
    else $error("outputs not quiet after reset");

  // Serial side: one taken rise per pin edge, output only moves with it
  a_edge_gap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    sclk_rise |=> !sclk_rise)
    else $error("one serial clock rise taken twice");
  a_data_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !(sclk_rise && !load_n) |=> $stable(data_o))
    else $error("serial output moved without enabled edge");

  // Latch side: one word per enable rise, held while the next shifts in
  a_latch_once: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pending_reg |=> !pending_reg)
    else $error("one enable rise latched twice");
  a_latch_hold: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !latch_pulse |=> $stable(latched_reg))
    else $error("latched word moved without enable rise");

  // Channel addresses must differ, or two channels would share words
  a_one_chan: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $onehot0(hit))
    else $error("word selects more than one channel");
  a_update_hit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pending_reg && (|hit) |=> update_o)
    else $error("matching word gave no update pulse");
  a_update_miss: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    pending_reg && !(|hit) |=> !update_o)
    else $error("update pulse for unmatched word");
  a_update_pulse: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    update_o |=> !update_o)
    else $error("update pulse longer than one cycle");
endmodule : serial_attenuator_control

// ===== logic/tap_lookup.sv
// Attenuation code to tap selection lookup with registered output
`timescale 1ns/1ns
module tap_lookup (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] code_i,
  output atten_pkg::setting_s setting_o
);
  atten_pkg::setting_s setting_reg;
  atten_pkg::setting_s setting_next;

  // Codes below threshold map one to one onto taps
  always_comb begin
    setting_next.mute = (code_i >= atten_pkg::MUTE_CODE);
    setting_next.tap = setting_next.mute ? atten_pkg::TAP_RESET
                                         : code_i[atten_pkg::TAP_BITS-1:0];
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      setting_reg <= atten_pkg::SETTING_RESET;
    end else begin
      setting_reg <= setting_next;
    end
  end

  assign setting_o = setting_reg;
endmodule : tap_lookup

// ===== sim/host_model.sv
// Host model: drives serial clock, load enable and data
`timescale 1ns/1ns
module host_model (
  input wire logic clk_i,
  input wire logic dout_i,
  output logic sclk_o,
  output logic load_n_o,
  output logic data_o
);
  logic [15:0] echo;
  initial begin
    sclk_o = 1'b0;
    load_n_o = 1'b1;
    data_o = 1'b0;
    echo = 16'h0000;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tick
  // Clock rests low between frames
  task automatic pulse(input logic b);
    data_o = b;
    tick(20);
    sclk_o = 1'b1;
    tick(20);
    sclk_o = 1'b0;
    echo = {echo[14:0], dout_i};
  endtask : pulse
  task automatic shift16(input atten_pkg::word_s w);
    for (int i = 15; i >= 0; i--) pulse(w[i]);
  endtask : shift16
  task automatic open_frame();
    load_n_o = 1'b0;
    tick(40);
  endtask : open_frame
  task automatic close_frame();
    tick(20);
    load_n_o = 1'b1;
    data_o = ~data_o;
  endtask : close_frame
endmodule : host_model

// ===== sim/tb.sv
// Self-checking bench for the serial attenuator control block
`timescale 1ns/1ns
module tb;
  logic clk_i, rst_n_i, sclk, load_n, din, dout, upd;
  logic [2:0] mute, exp_mute;
  logic [20:0] tap, exp_tap;
  int fails = 0;
  int cmp_count = 0;
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  host_model host_u (.clk_i(clk_i), .dout_i(dout), .sclk_o(sclk), .load_n_o(load_n),
    .data_o(din));
  serial_attenuator_control dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk),
    .load_n_i(load_n), .data_i(din), .data_o(dout), .mute_o(mute), .tap_o(tap),
    .update_o(upd));
  task automatic check(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1) begin
      fails++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic final_report();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  // Fixed window covers latch, lookup and update pulse
  task automatic expect_word(input logic [7:0] ch, input logic [7:0] code);
    int k;
    bit hit;
    k = (ch === atten_pkg::CHAN1_ADDR) ? 0 : (ch === atten_pkg::CHAN2_ADDR) ? 1 :
        (ch === atten_pkg::CHAN3_ADDR) ? 2 : -1;
    hit = 0;
    for (int i = 0; i < 12; i++) begin
      host_u.tick(1);
      hit |= (upd === 1'b1);
    end
    if (k >= 0) begin
      exp_mute[k] = (code >= atten_pkg::MUTE_CODE);
      exp_tap[7*k +: 7] = exp_mute[k] ? 7'h00 : code[6:0];
    end
    check(hit == (k >= 0), "update pulse");
    check(mute === exp_mute, "mute state");
    check(tap === exp_tap, "tap state");
  endtask : expect_word
  task automatic send(input logic [7:0] ch, input logic [7:0] code);
    host_u.open_frame();
    host_u.shift16({ch, code});
    host_u.close_frame();
    expect_word(ch, code);
  endtask : send
  initial begin
    #100000;
    fails++;
    final_report();
  end
  // Used at start and again mid-run: every channel must come back muted
  task automatic scen_reset();
    rst_n_i = 1'b0;
    exp_mute = 3'b111;
    exp_tap = '0;
    repeat (20) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    host_u.tick(4);
    check(mute === 3'b111 && tap === '0 && dout === 1'b0, "reset state");
    check(upd === 1'b0, "no update after reset");
  endtask : scen_reset
  task automatic scen_settings();
    send(8'h00, 8'h4E);
    send(8'h01, 8'h4F);
    send(8'h02, 8'h2A);
    send(8'h01, 8'h05);
    send(8'h02, 8'hFF);
    send(8'h03, 8'h10);
    send(8'h80, 8'h11);
  endtask : scen_settings
  // Clock edges with load high must not disturb the shift register
  task automatic scen_gate();
    repeat (4) host_u.pulse(1'b1);
    send(8'h00, 8'h07);
    check(host_u.echo === 16'h8011, "shifted out word");
  endtask : scen_gate
  // Two words in one frame: only the last 16 bits stay, the first pass on
  task automatic scen_chain();
    host_u.open_frame();
    host_u.shift16(16'h0133);
    check(host_u.echo === 16'h0000, "reset cleared shift path");
    host_u.shift16(16'h0020);
    host_u.close_frame();
    expect_word(8'h00, 8'h20);
    check(host_u.echo === 16'h0133, "chain pass through");
  endtask : scen_chain
  initial begin
    scen_reset();
    scen_settings();
    scen_gate();
    scen_reset();
    scen_chain();
    final_report();
  end
endmodule : tb
